// File: logic/lpsp_top.sv
`include "lpsp_defines.svh"

// Functional notes
// R1 - Grayscale input data is captured into the grayscale shift register on each shift clock rise.
// R2 - Each grayscale shift clock rise enters the new bit at the LSB and moves the MSB out.
// R3 - The grayscale serial output is the MSB of the grayscale shift register.
// R4 - With blanking low, each grayscale shift clock rise increments the PWM counter.
// R5 - A rising grayscale latch strobe copies the whole grayscale shift register into its latch.
// R6 - Dot correction input data is captured into its shift register on each dot shift clock rise.
// R7 - Each dot shift clock rise enters the new bit at the LSB and drives the MSB out.
// R8 - A rising dot latch strobe copies the dot correction shift register into its latch.
// R9 - With blanking high all outputs are off, the counter is held at 0 and PWM timing restarts.
// R10 - With blanking low each output is controlled only by the PWM timing logic.
// R11 - A channel is on while the counter is below its latched grayscale value.
module lpsp_top (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,

  // Grayscale serial port
  input wire lpsp_pkg::lpsp_port_t GRAY_PORT,
  output logic GRAY_SERIAL_OUT,

  // Dot correction serial port
  input wire lpsp_pkg::lpsp_port_t DOTCORR_PORT,
  output logic DOTCORR_SERIAL_OUT,

  // Blanking
  input wire logic BLANK_IN,

  // Channel outputs
  output logic [`LPSP_CHANNELS-1:0] CHANNEL_SINK_OUTPUT,
  output logic [`LPSP_DC_BITS-1:0] DOTCORR_LEVEL
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [`LPSP_SYNC_BITS-1:0] pins_raw;
  logic [`LPSP_SYNC_BITS-1:0] sync1_reg;
  logic [`LPSP_SYNC_BITS-1:0] sync2_reg;
  logic [`LPSP_SYNC_BITS-1:0] sync3_reg;

  assign pins_raw = {BLANK_IN, DOTCORR_PORT, GRAY_PORT};

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sync1_reg <= `LPSP_SYNC_RESET;
      sync2_reg <= `LPSP_SYNC_RESET;
      sync3_reg <= `LPSP_SYNC_RESET;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded pin levels and edges

  lpsp_pkg::lpsp_port_t gs_now;
  lpsp_pkg::lpsp_port_t gs_old;
  lpsp_pkg::lpsp_port_t dc_now;
  lpsp_pkg::lpsp_port_t dc_old;
  logic blank;
  logic gs_rise;
  logic gs_lat_rise;
  logic dc_rise;
  logic dc_lat_rise;

  assign gs_now = sync2_reg[`LPSP_SYNC_GS_LSB +: `LPSP_PORT_BITS];
  assign gs_old = sync3_reg[`LPSP_SYNC_GS_LSB +: `LPSP_PORT_BITS];
  assign dc_now = sync2_reg[`LPSP_SYNC_DC_LSB +: `LPSP_PORT_BITS];
  assign dc_old = sync3_reg[`LPSP_SYNC_DC_LSB +: `LPSP_PORT_BITS];
  assign blank = sync2_reg[`LPSP_SYNC_BLANK];

  assign gs_rise = gs_now.shift_clock & ~gs_old.shift_clock;
  assign gs_lat_rise = gs_now.latch_strobe & ~gs_old.latch_strobe;
  assign dc_rise = dc_now.shift_clock & ~dc_old.shift_clock;
  assign dc_lat_rise = dc_now.latch_strobe & ~dc_old.latch_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // Grayscale shift register and latch

  logic [`LPSP_GS_BITS-1:0] gs_shift_reg;
  logic [`LPSP_GS_BITS-1:0] gs_shift_next;
  logic [`LPSP_GS_BITS-1:0] gs_latch_reg;
  logic [`LPSP_GS_BITS-1:0] gs_latch_next;

  // LSB in, MSB out
  assign gs_shift_next = gs_rise ?
    {gs_shift_reg[`LPSP_GS_BITS-2:0], gs_now.serial_in} : gs_shift_reg; // [R1] [R2]
  assign gs_latch_next = gs_lat_rise ? gs_shift_reg : gs_latch_reg; // [R5]

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      gs_shift_reg <= `LPSP_GS_RESET;
      gs_latch_reg <= `LPSP_GS_RESET;
    end else begin
      gs_shift_reg <= gs_shift_next;
      gs_latch_reg <= gs_latch_next;
    end
  end

  assign GRAY_SERIAL_OUT = gs_shift_reg[`LPSP_GS_BITS-1]; // [R2] [R3]

  ////////////////////////////////////////////////////////////////////////////
  // Dot correction shift register and latch

  logic [`LPSP_DC_BITS-1:0] dc_shift_reg;
  logic [`LPSP_DC_BITS-1:0] dc_shift_next;
  logic [`LPSP_DC_BITS-1:0] dc_latch_reg;
  logic [`LPSP_DC_BITS-1:0] dc_latch_next;

  assign dc_shift_next = dc_rise ?
    {dc_shift_reg[`LPSP_DC_BITS-2:0], dc_now.serial_in} : dc_shift_reg; // [R6] [R7]
  assign dc_latch_next = dc_lat_rise ? dc_shift_reg : dc_latch_reg; // [R8]

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dc_shift_reg <= `LPSP_DC_RESET;
      dc_latch_reg <= `LPSP_DC_RESET;
    end else begin
      dc_shift_reg <= dc_shift_next;
      dc_latch_reg <= dc_latch_next;
    end
  end

  assign DOTCORR_SERIAL_OUT = dc_shift_reg[`LPSP_DC_BITS-1]; // [R7]
  assign DOTCORR_LEVEL = dc_latch_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Grayscale counter

  lpsp_pkg::lpsp_gray_t count_reg;
  lpsp_pkg::lpsp_gray_t count_next;

  // Blanking clears, shift clock rise advances
  assign count_next = blank ? `LPSP_COUNT_RESET : // [R9]
    (gs_rise ? count_reg + `LPSP_COUNT_STEP : count_reg); // [R4]

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      count_reg <= `LPSP_COUNT_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM compare per channel

  logic [`LPSP_CHANNELS-1:0] pwm_on;
  logic [`LPSP_CHANNELS-1:0] out_reg;
  logic [`LPSP_CHANNELS-1:0] out_next;

  for (genvar ch = 0; ch < `LPSP_CHANNELS; ch++) begin : g_chan
    assign pwm_on[ch] =
      count_reg < gs_latch_reg[ch*`LPSP_GS_WIDTH +: `LPSP_GS_WIDTH]; // [R11]
  end

  assign out_next = blank ? `LPSP_OUT_RESET : pwm_on; // [R9] [R10]

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      out_reg <= `LPSP_OUT_RESET;
    end else begin
      out_reg <= out_next;
    end
  end

  assign CHANNEL_SINK_OUTPUT = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_gs_edge;
    gs_rise;
  endsequence

  sequence s_blank_held;
    blank [*2];
  endsequence

  sequence s_dc_edge;
    dc_rise;
  endsequence

  sequence s_gray_pin_rise;
    $rose(GRAY_PORT.shift_clock);
  endsequence

  sequence s_gray_pin_latch;
    $rose(GRAY_PORT.latch_strobe);
  endsequence

  sequence s_dot_pin_rise;
    $rose(DOTCORR_PORT.shift_clock);
  endsequence

  sequence s_dot_pin_latch;
    $rose(DOTCORR_PORT.latch_strobe);
  endsequence

  sequence s_blank_pin_rise;
    $rose(BLANK_IN);
  endsequence

  gray_shift_a: assert property ( // [R1] [R2]
    s_gs_edge |=> gs_shift_reg ==
      {$past(gs_shift_reg[`LPSP_GS_BITS-2:0]), $past(gs_now.serial_in)})
    else $error("grayscale shift wrong");

  gray_sout_a: assert property ( // [R3]
    s_gs_edge |=> GRAY_SERIAL_OUT == $past(gs_shift_reg[`LPSP_GS_BITS-2]))
    else $error("grayscale serial out wrong");

  gray_hold_a: assert property ( // [R1]
    !gs_rise |=> $stable(gs_shift_reg))
    else $error("grayscale shift moved without clock");

  count_step_a: assert property ( // [R4]
    (s_gs_edge and !blank) |=> count_reg == $past(count_reg) + `LPSP_COUNT_STEP)
    else $error("counter did not step");

  count_still_a: assert property ( // [R4]
    (!gs_rise && !blank) |=> count_reg == $past(count_reg))
    else $error("counter moved without clock");

  gray_latch_a: assert property ( // [R5]
    gs_lat_rise |=> gs_latch_reg == $past(gs_shift_reg))
    else $error("grayscale latch not loaded");

  latch_keep_a: assert property ( // [R5]
    !gs_lat_rise |=> $stable(gs_latch_reg))
    else $error("grayscale latch changed");

  dot_shift_a: assert property ( // [R6] [R7]
    s_dc_edge |=> DOTCORR_SERIAL_OUT == $past(dc_shift_reg[`LPSP_DC_BITS-2])
      && dc_shift_reg[0] == $past(dc_now.serial_in))
    else $error("dot correction shift wrong");

  dot_latch_a: assert property ( // [R8]
    dc_lat_rise |=> dc_latch_reg == $past(dc_shift_reg) ##1 $stable(dc_latch_reg))
    else $error("dot correction latch wrong");

  blank_off_a: assert property ( // [R9]
    s_blank_held |-> CHANNEL_SINK_OUTPUT == `LPSP_OUT_RESET
      && count_reg == `LPSP_COUNT_RESET)
    else $error("blanking did not clear");

  pwm_chan_a: assert property ( // [R10] [R11]
    (!blank && count_reg < gs_latch_reg[`LPSP_GS_WIDTH-1:0])
      |=> CHANNEL_SINK_OUTPUT[0])
    else $error("channel 0 not on");

  pwm_off_a: assert property ( // [R10] [R11]
    (!blank && count_reg >= gs_latch_reg[`LPSP_GS_BITS-1 -: `LPSP_GS_WIDTH])
      |=> !CHANNEL_SINK_OUTPUT[`LPSP_CHANNELS-1])
    else $error("channel 15 not off");

  gray_pin_edge_a: assert property ( // [R1] [R4]
    s_gray_pin_rise |-> ##2 gs_rise)
    else $error("grayscale shift clock edge lost");

  gray_pin_latch_a: assert property ( // [R5]
    s_gray_pin_latch |-> ##2 gs_lat_rise)
    else $error("grayscale latch edge lost");

  dot_pin_edge_a: assert property ( // [R6]
    s_dot_pin_rise |-> ##2 dc_rise)
    else $error("dot correction shift clock edge lost");

  dot_pin_latch_a: assert property ( // [R8]
    s_dot_pin_latch |-> ##2 dc_lat_rise)
    else $error("dot correction latch edge lost");

  blank_pin_a: assert property ( // [R9]
    s_blank_pin_rise |-> ##2 blank)
    else $error("blanking rise lost");

  blank_drop_a: assert property ( // [R10]
    $fell(BLANK_IN) |-> ##2 !blank)
    else $error("blanking release lost");

  dot_hold_a: assert property ( // [R6]
    !dc_rise |=> $stable(dc_shift_reg))
    else $error("dot correction shift moved without clock");

  dot_keep_a: assert property ( // [R8]
    !dc_lat_rise |=> $stable(dc_latch_reg))
    else $error("dot correction latch changed");

  blank_now_a: assert property ( // [R9]
    blank |=> CHANNEL_SINK_OUTPUT == `LPSP_OUT_RESET
      && count_reg == `LPSP_COUNT_RESET)
    else $error("blanking did not clear at once");

  // Every channel against its own latched level
  for (genvar ch = 0; ch < `LPSP_CHANNELS; ch++) begin : g_chan_chk
    chan_on_a: assert property (@(posedge CLOCK) disable iff (RST) // [R10] [R11]
      (!blank && count_reg < gs_latch_reg[ch*`LPSP_GS_WIDTH +: `LPSP_GS_WIDTH])
        |=> CHANNEL_SINK_OUTPUT[ch])
      else $error("channel stayed off below its level");

    chan_off_a: assert property (@(posedge CLOCK) disable iff (RST) // [R9] [R11]
      (blank || count_reg >= gs_latch_reg[ch*`LPSP_GS_WIDTH +: `LPSP_GS_WIDTH])
        |=> !CHANNEL_SINK_OUTPUT[ch])
      else $error("channel stayed on at or above its level");
  end

endmodule : lpsp_top

// File: pkg/lpsp_defines.svh
`ifndef LPSP_DEFINES_SVH
`define LPSP_DEFINES_SVH

// Channel and field sizes
`define LPSP_CHANNELS 16
`define LPSP_GS_WIDTH 12
`define LPSP_DC_WIDTH 7
`define LPSP_GS_BITS 192
`define LPSP_DC_BITS 112

// Synchroniser vector layout
`define LPSP_SYNC_BITS 7
`define LPSP_SYNC_GS_LSB 0
`define LPSP_SYNC_DC_LSB 3
`define LPSP_SYNC_BLANK 6
`define LPSP_PORT_BITS 3

// Reset values
`define LPSP_SYNC_RESET 7'h00
`define LPSP_GS_RESET 192'h0
`define LPSP_DC_RESET 112'h0
`define LPSP_COUNT_RESET 12'h000
`define LPSP_COUNT_STEP 12'h001
`define LPSP_OUT_RESET 16'h0000

`endif

// File: pkg/lpsp_pkg.sv
`include "lpsp_defines.svh"

package lpsp_pkg;

  // One serial port: data, shift clock, latch strobe
  typedef struct packed {
    logic latch_strobe;
    logic shift_clock;
    logic serial_in;
  } lpsp_port_t;

  typedef logic [`LPSP_GS_WIDTH-1:0] lpsp_gray_t;

endpackage : lpsp_pkg

// File: tb/lpsp_ctrl_model.sv
// Display controller driving one serial port
module lpsp_ctrl_model (
  // Clock
  input wire logic clk,
  // Serial port pins
  output lpsp_pkg::lpsp_port_t port
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    port = 3'h0;
  end

  // Shift clock idles low between bits
  task automatic shift_bit(input logic b);
    @(posedge clk);
    port.serial_in <= b;
    repeat (6) @(posedge clk);
    port.shift_clock <= 1'b1;
    repeat (6) @(posedge clk);
    port.shift_clock <= 1'b0;
    port.serial_in <= ~b;
  endtask : shift_bit

  // Latch edge only after shifting is over
  task automatic latch_pulse();
    repeat (6) @(posedge clk);
    port.latch_strobe <= 1'b1;
    repeat (6) @(posedge clk);
    port.latch_strobe <= 1'b0;
  endtask : latch_pulse
endmodule : lpsp_ctrl_model

// File: tb/lpsp_top_tb.sv
`include "lpsp_defines.svh"

module lpsp_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock;
  logic rst;
  logic blank;
  lpsp_pkg::lpsp_port_t gray_port;
  lpsp_pkg::lpsp_port_t dot_port;
  logic gray_out;
  logic dot_out;
  logic [`LPSP_CHANNELS-1:0] sink;
  logic [`LPSP_DC_BITS-1:0] dot_level;
  int n_mismatch = 0;
  int n_checks = 0;

  lpsp_top i_dut (.CLOCK(clock), .RST(rst), .GRAY_PORT(gray_port), .GRAY_SERIAL_OUT(gray_out),
    .DOTCORR_PORT(dot_port), .DOTCORR_SERIAL_OUT(dot_out), .BLANK_IN(blank),
    .CHANNEL_SINK_OUTPUT(sink), .DOTCORR_LEVEL(dot_level));
  lpsp_ctrl_model i_gray (.clk(clock), .port(gray_port));
  lpsp_ctrl_model i_dot (.clk(clock), .port(dot_port));

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [191:0] got, input logic [191:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  // Channel n holds n*257; on while count below it
  function automatic logic [15:0] pwm_exp(input int k);
    logic [15:0] e;
    for (int n = 0; n < 16; n++) e[n] = (k < n * 257);
    return e;
  endfunction : pwm_exp

  task automatic test_gray();
    logic [191:0] pat;
    int k;
    for (int n = 0; n < 16; n++) pat[12*n +: 12] = 12'(n * 257);
    for (int i = 191; i >= 0; i--) i_gray.shift_bit(pat[i]);
    check(gray_out, pat[191], "gray out msb");
    i_gray.latch_pulse();
    repeat (4) @(posedge clock);
    check(sink, 0, "blanked sinks");
    repeat (4) i_gray.shift_bit(1'b1);
    check(gray_out, pat[187], "gray out next");
    blank <= 1'b0;
    repeat (6) @(posedge clock);
    check(sink, pwm_exp(0), "pwm count 0");
    for (k = 1; k <= 257; k++) begin
      i_gray.shift_bit(1'b0);
      if (k == 1 || k == 256 || k == 257) check(sink, pwm_exp(k), "pwm count");
    end
    blank <= 1'b1;
    repeat (6) @(posedge clock);
    check(sink, 0, "blank again");
    blank <= 1'b0;
    repeat (6) @(posedge clock);
    check(sink, pwm_exp(0), "counter cleared");
    $display("test gray done");
  endtask : test_gray

  task automatic test_dot();
    logic [111:0] pat;
    for (int n = 0; n < 16; n++) pat[7*n +: 7] = 7'(n * 9 + 5);
    for (int i = 111; i >= 0; i--) i_dot.shift_bit(pat[i]);
    check(dot_out, pat[111], "dot out msb");
    i_dot.latch_pulse();
    repeat (4) @(posedge clock);
    check(dot_level, pat, "dot latch");
    repeat (3) i_dot.shift_bit(1'b0);
    check(dot_out, pat[108], "dot out next");
    check(dot_level, pat, "dot latch held");
    $display("test dot done");
  endtask : test_dot

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rst = 1'b1;
    blank = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    test_gray();
    test_dot();
    complete_run();
  end

  // Whole run needs about 7000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    $display("Error at %0t: run timed out", $time);
    complete_run();
  end
endmodule : lpsp_top_tb
